// file: hw/usbirq_cfg.svh
// register map, field positions, reset values and timing of the usb irq block
`ifndef USBIRQ_CFG_SVH
`define USBIRQ_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define USBIRQ_PEND_OFS     8'h00
`define USBIRQ_MASK_OFS     8'h04
`define USBIRQ_CLR_OFS      8'h08
`define USBIRQ_EPRST_OFS    8'h0c
`define USBIRQ_CSR0_OFS     8'h10

// ==========================================================
// field positions of the pending, mask and clear registers
`define USBIRQ_BIT_SUSP     8
`define USBIRQ_BIT_RSM      9
`define USBIRQ_BIT_LOCAL_RESUME_PENDING   10
`define USBIRQ_BIT_SOF      11
`define USBIRQ_BIT_BUSRES   12
`define USBIRQ_BIT_WAKE     13
`define USBIRQ_PEND_VALID   14'h3f3f
`define USBIRQ_CLR_VALID    14'h3f00
`define USBIRQ_EPRST_VALID  6'h3f

// ==========================================================
// endpoint control and status fields
`define USBIRQ_NUM_EP       6
`define USBIRQ_CNT_W        11
`define USBIRQ_CSR_FLAG     0
`define USBIRQ_CSR_TGL      11
`define USBIRQ_CSR_CNT_LSB  16

// ==========================================================
// reset values
`define USBIRQ_MASK_RST     14'h0200
`define USBIRQ_PEND_RST     14'h0000
`define USBIRQ_EPRST_RST    6'h00

// ==========================================================
// timing
`define USBIRQ_CLK_NS       4
`define USBIRQ_SUSP_NS      3000000
`define USBIRQ_SUSP_CYC     ((`USBIRQ_SUSP_NS + `USBIRQ_CLK_NS - 1) / `USBIRQ_CLK_NS)
`define USBIRQ_IDLE_W       20

`endif

// file: hw/usbirq_ep.sv
// one endpoint: fifo pointers, received byte count and data toggle
`include "usbirq_cfg.svh"

module usbirq_ep
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	// endpoint reset from register or bus reset
	input  wire logic                     ep_reset,
	// traffic strobes
	input  wire logic                     rx_byte,
	input  wire logic                     rd_byte,
	input  wire logic                     toggle_flip,
	// state seen by software
	output logic [`USBIRQ_CNT_W-1:0]      received_byte_count,
	output logic [`USBIRQ_CNT_W-1:0]      fifo_wr_ptr,
	output logic [`USBIRQ_CNT_W-1:0]      fifo_rd_ptr,
	output logic                          data_toggle
);

	usbirq_pkg::usbirq_ep_state_t s;
	usbirq_pkg::usbirq_ep_state_t next_s;
	logic                         take_rd;

	// ==========================================================
	// next state
	always_comb
	begin
		next_s  = s;
		take_rd = rd_byte && (s.count != '0);
		if (ep_reset)
		begin
			next_s = '0; // pointers, count and toggle to data0
		end
		else
		begin
			if (rx_byte)
				next_s.wr_ptr = s.wr_ptr + 1'b1;
			if (take_rd)
				next_s.rd_ptr = s.rd_ptr + 1'b1;
			if (rx_byte && !take_rd)
				next_s.count = s.count + 1'b1;
			else if (take_rd && !rx_byte)
				next_s.count = s.count - 1'b1;
			if (toggle_flip)
				next_s.toggle = ~s.toggle;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// outputs straight from flops
	assign received_byte_count = s.count;
	assign fifo_wr_ptr         = s.wr_ptr;
	assign fifo_rd_ptr         = s.rd_ptr;
	assign data_toggle         = s.toggle;

endmodule : usbirq_ep

// file: hw/usbirq_pkg.sv
// types of the usb irq block
`include "usbirq_cfg.svh"

package usbirq_pkg;

	// ==========================================================
	// bus power state
	typedef enum logic
	{
		USBIRQ_ACTIVE,
		USBIRQ_SUSPENDED
	} usbirq_mode_t;

	// ==========================================================
	// whole state of the top module
	typedef struct packed
	{
		usbirq_mode_t              mode;
		logic [13:0]               pending;
		logic [13:0]               mask;
		logic [5:0]                ep_rst;
		logic [`USBIRQ_IDLE_W-1:0] idle_cnt;
		logic                      bus_rst_q;
		logic                      local_req_q;
		logic                      ep0_ready;
		logic                      dp_valid;
		logic                      dp_write;
		logic [7:0]                dp_addr;
		logic                      rd_done;
		logic [31:0]               rdata;
	} usbirq_state_t;

	// ==========================================================
	// whole state of one endpoint
	typedef struct packed
	{
		logic [`USBIRQ_CNT_W-1:0] wr_ptr;
		logic [`USBIRQ_CNT_W-1:0] rd_ptr;
		logic [`USBIRQ_CNT_W-1:0] count;
		logic                     toggle;
	} usbirq_ep_state_t;

endpackage : usbirq_pkg

// file: hw/usbirq_top.sv
// usb device irq status, clear, mask and endpoint reset over ahb-lite
//
// Functional notes
// - each detected start-of-frame token sets the frame start pending bit
// - end of a host bus reset sets the bus reset done pending bit
// - after bus reset ends, endpoint zero is ready for host requests
// - host resume or reset sets wake pending, sticky until software clears it
// - writing ones to clear register bits 8..13 clears pending, zeros ignored
// - endpoint reset bit n resets fifo and received count of endpoint n
// - endpoint reset bit also returns the data toggle to data0
// - while reset bit is one, fifo pointers held at zero, count reads zero
// - three milliseconds without bus activity sets suspend pending, enters suspend
// - host resume signalling at the port sets resume pending
// - while suspended, rising local resume request sets local resume pending
// - endpoint pending bits clear only through the endpoint status register
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`include "usbirq_cfg.svh"

module usbirq_top
#(
	parameter logic [`USBIRQ_IDLE_W-1:0] SUSPEND_CYCLES =
		`USBIRQ_IDLE_W'(`USBIRQ_SUSP_CYC)
)
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// bus events from the usb line logic
	input  wire logic        sof_token,
	input  wire logic        bus_reset,
	input  wire logic        bus_activity,
	input  wire logic        host_resume,
	input  wire logic        local_resume_req,
	// endpoint traffic
	input  wire logic [5:0]  ep_event,
	input  wire logic [5:0]  ep_rx_byte,
	input  wire logic [5:0]  ep_rd_byte,
	input  wire logic [5:0]  ep_toggle_flip,
	// status toward the usb line logic
	output logic [5:0]       ep_data_toggle,
	output logic             ep0_ready,
	output logic             suspended,
	// interrupt
	output logic             usb_irq
);

	localparam int NEP = `USBIRQ_NUM_EP;
	localparam int CW  = `USBIRQ_CNT_W;

	usbirq_pkg::usbirq_state_t s;
	usbirq_pkg::usbirq_state_t next_s;

	logic [NEP-1:0][CW-1:0] ep_count;
	logic [NEP-1:0]         ep_tgl;
	logic [NEP-1:0]         ep_rst_any;
	logic                   accept;
	logic                   wr_phase;
	logic                   rd_phase;
	logic [13:0]            set_bits;
	logic [13:0]            clr_bits;
	logic                   rst_start;
	logic                   rst_end;
	logic                   ep_hit;
	logic [2:0]             ep_idx;
	logic [31:0]            rd_word;

	// ==========================================================
	// address decode helpers

	// endpoint status register index hit by an address
	function automatic logic ep_csr_hit(input logic [7:0] a);
		logic [7:0] top;
		top = `USBIRQ_CSR0_OFS + 8'(4 * NEP);
		ep_csr_hit = (a >= `USBIRQ_CSR0_OFS) && (a < top);
	endfunction : ep_csr_hit

	// endpoint number of an endpoint status address
	function automatic logic [2:0] ep_csr_idx(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - `USBIRQ_CSR0_OFS;
		ep_csr_idx = rel[4:2];
	endfunction : ep_csr_idx

	// ==========================================================
	// endpoints
	genvar g;
	generate
		for (g = 0; g < NEP; g++)
		begin : gen_ep
			// a bus reset also restarts every endpoint
			assign ep_rst_any[g] = s.ep_rst[g] || bus_reset;

			usbirq_ep u_ep
			(
				.core_clk            (core_clk),
				.rst_n               (rst_n),
				.ep_reset            (ep_rst_any[g]),
				.rx_byte             (ep_rx_byte[g]),
				.rd_byte             (ep_rd_byte[g]),
				.toggle_flip         (ep_toggle_flip[g]),
				.received_byte_count (ep_count[g]),
				.fifo_wr_ptr         (),
				.fifo_rd_ptr         (),
				.data_toggle         (ep_tgl[g])
			);
		end
	endgenerate

	// ==========================================================
	// bus phase decode
	always_comb
	begin
		accept   = hsel && htrans[1] && hready;
		wr_phase = s.dp_valid && s.dp_write;
		rd_phase = s.dp_valid && !s.dp_write;
		ep_hit   = ep_csr_hit(s.dp_addr);
		ep_idx   = ep_csr_idx(s.dp_addr);
	end

	// ==========================================================
	// read multiplexer, sampled in the wait cycle of a read
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (s.dp_addr == `USBIRQ_PEND_OFS)
			rd_word[13:0] = s.pending;
		else if (s.dp_addr == `USBIRQ_MASK_OFS)
			rd_word[13:0] = s.mask;
		else if (s.dp_addr == `USBIRQ_EPRST_OFS)
			rd_word[5:0] = s.ep_rst;
		else if (ep_hit)
		begin
			rd_word[`USBIRQ_CSR_FLAG] = s.pending[ep_idx];
			rd_word[`USBIRQ_CSR_TGL]  = ep_tgl[ep_idx];
			rd_word[`USBIRQ_CSR_CNT_LSB +: CW] = ep_count[ep_idx];
		end
	end

	// ==========================================================
	// event detection
	always_comb
	begin
		rst_start = bus_reset && !s.bus_rst_q;
		rst_end   = !bus_reset && s.bus_rst_q;
		set_bits  = 14'h0000;
		set_bits[5:0] = ep_event;
		set_bits[`USBIRQ_BIT_SOF]    = sof_token;
		set_bits[`USBIRQ_BIT_BUSRES] = rst_end;
		set_bits[`USBIRQ_BIT_WAKE]   = host_resume || rst_start;
		set_bits[`USBIRQ_BIT_RSM]    = host_resume;
		set_bits[`USBIRQ_BIT_LOCAL_RESUME_PENDING] = local_resume_req && !s.local_req_q &&
			(s.mode == usbirq_pkg::USBIRQ_SUSPENDED);
		if (s.mode == usbirq_pkg::USBIRQ_ACTIVE && !bus_activity &&
			s.idle_cnt == SUSPEND_CYCLES - 1'b1)
			set_bits[`USBIRQ_BIT_SUSP] = 1'b1;
	end

	// ==========================================================
	// software clears
	always_comb
	begin
		clr_bits = 14'h0000;
		if (wr_phase && s.dp_addr == `USBIRQ_CLR_OFS)
			clr_bits = hwdata[13:0] & `USBIRQ_CLR_VALID;
		else if (wr_phase && ep_hit && !hwdata[`USBIRQ_CSR_FLAG])
			clr_bits[ep_idx] = 1'b1;
	end

	// ==========================================================
	// next state
	always_comb
	begin
		next_s = s;

		// sticky pending bits, a new event wins over a clear
		next_s.pending = ((s.pending & ~clr_bits) | set_bits) &
			`USBIRQ_PEND_VALID;

		// edge history
		next_s.bus_rst_q   = bus_reset;
		next_s.local_req_q = local_resume_req;

		// endpoint zero readiness follows the bus reset
		if (bus_reset)
			next_s.ep0_ready = 1'b0;
		else if (rst_end)
			next_s.ep0_ready = 1'b1;

		// idle timer and suspend state
		if (bus_activity || host_resume || bus_reset)
		begin
			next_s.idle_cnt = '0;
			next_s.mode     = usbirq_pkg::USBIRQ_ACTIVE;
		end
		else if (s.mode == usbirq_pkg::USBIRQ_ACTIVE)
		begin
			if (set_bits[`USBIRQ_BIT_SUSP])
			begin
				next_s.mode     = usbirq_pkg::USBIRQ_SUSPENDED;
				next_s.idle_cnt = '0;
			end
			else
				next_s.idle_cnt = s.idle_cnt + 1'b1;
		end

		// data phase of a write
		if (wr_phase)
		begin
			if (s.dp_addr == `USBIRQ_MASK_OFS)
				next_s.mask = hwdata[13:0] & `USBIRQ_PEND_VALID;
			else if (s.dp_addr == `USBIRQ_EPRST_OFS)
				next_s.ep_rst = hwdata[5:0] & `USBIRQ_EPRST_VALID;
		end

		// read takes one wait cycle so a just-written value is seen
		if (rd_phase && !s.rd_done)
		begin
			next_s.rdata   = rd_word;
			next_s.rd_done = 1'b1;
		end

		// address phase capture when the bus moves on
		if (hreadyout)
		begin
			next_s.dp_valid = accept;
			next_s.dp_write = hwrite;
			next_s.dp_addr  = haddr[7:0];
			next_s.rd_done  = 1'b0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s          <= '0;
			s.mode     <= usbirq_pkg::USBIRQ_ACTIVE;
			s.pending  <= `USBIRQ_PEND_RST;
			s.mask     <= `USBIRQ_MASK_RST;
			s.ep_rst   <= `USBIRQ_EPRST_RST;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// outputs
	assign hreadyout      = !(rd_phase && !s.rd_done);
	assign hresp          = 1'b0;
	assign hrdata         = s.rdata;
	assign ep_data_toggle = ep_tgl;
	assign ep0_ready      = s.ep0_ready;
	assign suspended      = (s.mode == usbirq_pkg::USBIRQ_SUSPENDED);
	assign usb_irq        = |(s.pending & s.mask);

endmodule : usbirq_top

// file: verification/test_usb_device_irq_clear_ep_reset.sv
// self-checking bench of the usb irq block
`include "usbirq_cfg.svh"

module test_usb_device_irq_clear_ep_reset;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 20;
	logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic        sof_token, bus_reset, bus_activity, host_resume;
	logic        local_resume_req, ep0_ready, suspended, usb_irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r, v;
	logic [5:0]  ep_event, ep_rx_byte, ep_rd_byte, ep_toggle_flip;
	logic [5:0]  ep_data_toggle;
	int          error_cnt, num_checks, cyc, epnd, emsk, k, a;

	usbirq_top #(.SUSPEND_CYCLES(`USBIRQ_IDLE_W'(SC))) uut
	(
		.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.sof_token, .bus_reset, .bus_activity, .host_resume,
		.local_resume_req, .ep_event, .ep_rx_byte, .ep_rd_byte,
		.ep_toggle_flip, .ep_data_toggle, .ep0_ready, .suspended, .usb_irq
	);
	usbirq_host_model host
	(
		.core_clk, .sof_token, .bus_reset, .bus_activity, .host_resume
	);

	// clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// compare one result with the model
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one single ahb-lite transfer
	task automatic ahb(input logic w, input int ad, input logic [31:0] d);
		haddr <= 32'(ad);
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		r = hrdata;
	endtask : ahb

	// read a register and compare
	task automatic rd(input int ad, input logic [31:0] e);
		ahb(1'b0, ad, 32'h0);
		chk($sformatf("reg %h", ad), e, r);
		chk("resp", 32'h0, {31'h0, hresp});
	endtask : rd

	// pending register and interrupt line
	task automatic pend_chk;
		rd(`USBIRQ_PEND_OFS, epnd);
		chk("irq", {31'h0, (epnd & emsk) != 0}, {31'h0, usb_irq});
	endtask : pend_chk

	// verdict
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// watchdog
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	// main sequence
	initial
	begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{local_resume_req, ep_event, ep_rx_byte} = '0;
		{ep_rd_byte, ep_toggle_flip} = '0;
		hsize = 3'h2;
		hsel = 1'b1;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		void'($urandom(40650));
		epnd = 0;
		emsk = `USBIRQ_MASK_RST;
		rd(`USBIRQ_MASK_OFS, 32'h200);
		rd(`USBIRQ_PEND_OFS, 32'h0);
		rd(`USBIRQ_EPRST_OFS, 32'h0);
		rd(`USBIRQ_CLR_OFS, 32'h0);
		ahb(1'b1, 'hfc, 32'hffffffff);
		rd('hfc, 32'h0);
		chk("ep0", 32'h0, {31'h0, ep0_ready});
		$display("test reset done");
		host.sof();
		epnd |= 'h0800;
		pend_chk();
		host.resume();
		epnd |= 'h2200;
		pend_chk();
		host.bus_rst(5);
		@(posedge core_clk);
		epnd |= 'h3000;
		pend_chk();
		chk("ep0", 32'h1, {31'h0, ep0_ready});
		v = $urandom;
		ahb(1'b1, `USBIRQ_MASK_OFS, v);
		emsk = v & 'h3f3f;
		rd(`USBIRQ_MASK_OFS, emsk);
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 32'h0 : $urandom;
			host.sof();
			host.resume();
			epnd |= 'h2a00;
			ahb(1'b1, `USBIRQ_CLR_OFS, v);
			epnd &= ~(v & 'h3f00);
			pend_chk();
		end
		$display("test events done");
		host.go_idle(1'b1);
		repeat (SC + 4) @(posedge core_clk);
		chk("susp", 32'h1, {31'h0, suspended});
		local_resume_req <= 1'b1;
		repeat (2) @(posedge core_clk);
		epnd |= 'h0500;
		pend_chk();
		host.go_idle(1'b0);
		repeat (2) @(posedge core_clk);
		chk("susp", 32'h0, {31'h0, suspended});
		ahb(1'b1, `USBIRQ_CLR_OFS, 32'h400);
		local_resume_req <= 1'b0;
		@(posedge core_clk) local_resume_req <= 1'b1;
		repeat (2) @(posedge core_clk);
		epnd &= ~'h400;
		pend_chk();
		$display("test suspend done");
		for (int n = 0; n < 6; n++)
		begin
			k = $urandom_range(7, 1);
			a = `USBIRQ_CSR0_OFS + 4 * n;
			ep_event[n] <= 1'b1;
			ep_toggle_flip[n] <= 1'b1;
			@(posedge core_clk);
			{ep_event, ep_toggle_flip} <= 12'h000;
			repeat (k)
			begin
				ep_rx_byte[n] <= 1'b1;
				@(posedge core_clk);
			end
			ep_rx_byte <= 6'h00;
			@(posedge core_clk);
			epnd |= 1 << n;
			rd(a, (k << 16) | 'h801);
			ahb(1'b1, `USBIRQ_CLR_OFS, 32'h3fff);
			epnd &= ~'h3f00;
			pend_chk();
			ahb(1'b1, `USBIRQ_EPRST_OFS, 32'hffffffc0 | (1 << n));
			rd(`USBIRQ_EPRST_OFS, 1 << n);
			ep_rx_byte[n] <= 1'b1;
			@(posedge core_clk) ep_rx_byte <= 6'h00;
			rd(a, 32'h1);
			chk("tgl", 32'h0, {31'h0, ep_data_toggle[n]});
			ahb(1'b1, `USBIRQ_EPRST_OFS, 32'h0);
			ahb(1'b1, a, 32'h0);
			epnd &= ~(1 << n);
			pend_chk();
		end
		$display("test endpoints done");
		complete_run();
	end
endmodule : test_usb_device_irq_clear_ep_reset

// file: verification/usbirq_host_model.sv
// behavioural usb host driving bus events
module usbirq_host_model
(
	// clock
	input wire logic core_clk,
	// bus events toward the device
	output logic     sof_token,
	output logic     bus_reset,
	output logic     bus_activity,
	output logic     host_resume
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet bus with traffic running
	initial
	begin
		sof_token = 1'b0;
		bus_reset = 1'b0;
		bus_activity = 1'b1;
		host_resume = 1'b0;
	end

	// one start-of-frame token
	task automatic sof;
		@(posedge core_clk) sof_token <= 1'b1;
		@(posedge core_clk) sof_token <= 1'b0;
	endtask : sof

	// resume signalling
	task automatic resume;
		@(posedge core_clk) host_resume <= 1'b1;
		@(posedge core_clk) host_resume <= 1'b0;
	endtask : resume

	// bus reset held for len cycles
	task automatic bus_rst(input int len);
		@(posedge core_clk) bus_reset <= 1'b1;
		repeat (len) @(posedge core_clk);
		bus_reset <= 1'b0;
	endtask : bus_rst

	// stop or restart all bus traffic
	task automatic go_idle(input logic on);
		@(posedge core_clk) bus_activity <= !on;
	endtask : go_idle
endmodule : usbirq_host_model

// file: verification/usbirq_sva.sv
// port checker of the usb irq block
`include "usbirq_cfg.svh"

module usbirq_sva
#(
	parameter logic [`USBIRQ_IDLE_W-1:0] SUSPEND_CYCLES = 20'h00014
)
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// register bus
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// usb side
	input wire logic       bus_reset,
	input wire logic       bus_activity,
	input wire logic       host_resume,
	input wire logic [5:0] ep_data_toggle,
	input wire logic       ep0_ready,
	input wire logic       suspended
);
	int idle;

	// idle bus cycles, saturating
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || bus_activity || host_resume || bus_reset)
			idle <= 0;
		else if (idle < 1000)
			idle <= idle + 1;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// bus transfers
	sequence s_acc;
		hsel && htrans[1] && hready;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence

	a_read_one_wait: assert property (s_acc and !hwrite |=> s_rd_ans)
		else $error("read data phase not one wait");
	a_write_no_wait: assert property (s_acc and hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");

	// ==========================================================
	// usb events
	a_ep0_after_rst: assert property ($fell(bus_reset) |=> ep0_ready)
		else $error("endpoint zero not ready after reset");
	a_ep0_in_rst: assert property (bus_reset |=> !ep0_ready)
		else $error("endpoint zero ready during reset");
	a_toggle_data0: assert property (bus_reset |=> ep_data_toggle == 6'h00)
		else $error("toggle not data0 after reset");
	a_susp_not_early: assert property ($rose(suspended) |-> idle >= SUSPEND_CYCLES - 1)
		else $error("suspend entered too early");
	a_susp_not_late: assert property (idle == SUSPEND_CYCLES + 2 |-> suspended)
		else $error("suspend not entered");
	a_wake_leaves: assert property (bus_activity || host_resume |=> !suspended)
		else $error("suspend kept under activity");
endmodule : usbirq_sva

bind usbirq_top usbirq_sva #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_sva
(
	.core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .bus_reset, .bus_activity, .host_resume, .ep_data_toggle,
	.ep0_ready, .suspended
);
